// ### hw/pcra_core.sv
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`include "pcra_consts.svh"
module pcra_core
  import pcra_pkg::*;
(
  input  wire logic          ref_clk,    // instruction clock, 20 MHz
  input  wire logic          nrst,       // async reset, active low
  input  wire logic          cen,        // clock enable, freezes all state
  input  wire pcra_rst_src_t reset_src,  // cause of the last reset
  input  wire logic          hsel,       // bus slave select
  input  wire logic [31:0]   haddr,      // bus byte address
  input  wire logic [1:0]    htrans,     // bus transfer type
  input  wire logic          hwrite,     // bus write
  input  wire logic [2:0]    hsize,      // bus transfer size
  input  wire logic [31:0]   hwdata,     // bus write data
  input  wire logic          hready,     // bus ready
  output logic               hreadyout,  // slave ready
  output logic      [31:0]   hrdata,     // bus read data
  output logic               hresp,      // bus response
  output pcra_rom_req_t      rom_req,    // program rom read request
  input  wire logic [15:0]   rom_data,   // program rom word
  output logic      [15:0]   pc_out,     // current program counter
  output logic               busy        // table read in flight
);

  pcra_core_st_t q;           // registered state
  pcra_core_st_t n;           // next state
  pcra_reg_req_t reg_req;     // register access from the slave
  logic [31:0]   reg_rdata;   // register read mux
  logic          cmd_go;      // command accepted this cycle
  pcra_op_t      cmd_op;      // decoded command
  logic [15:0]   pc_sum;      // pc after add or subtract
  logic [3:0]    sp_dec;      // stack pointer minus one
  logic [15:0]   stack_top;   // entry a return pops
  logic [2:0]    sp_idx;      // slot an interrupt pushes into

  // bus front end
  pcra_ahb_slave u_slave (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .cen       (cen),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .reg_req   (reg_req),
    .reg_rdata (reg_rdata)
  );

  // computed jump arithmetic on the program counter
  pcra_pc_add u_pc_add (
    .pc_in  (q.pc),
    .addend (q.acc),
    .sub    (cmd_op == OP_SUBPC),
    .pc_out (pc_sum)
  );

  // commands are only taken while no table read is in flight
  assign cmd_op    = pcra_op_t'(reg_req.wdata[`PCRA_CMD_OP]);
  assign cmd_go    = reg_req.wr && (reg_req.addr == `PCRA_OFS_CMD) && (q.state == ST_IDLE);
  assign sp_dec    = q.sp - `PCRA_INC4;
  assign sp_idx    = q.sp[`PCRA_SP_IDX];
  assign stack_top = q.stack[sp_dec[`PCRA_SP_IDX]];

  // next-state logic
  always_comb begin
    n        = q;
    n.rom.rd = 1'b0;  // request lasts one cycle
    // latch the reset cause on the first enabled edge after release
    if (q.cause_pend) begin
      n.cause_pend = 1'b0;
      case (reset_src)
        SRC_WDT: begin
          n.flags[`PCRA_PF_TO] = 1'b0;
          n.flags[`PCRA_PF_PD] = 1'b0;
        end
        SRC_EXT: begin
          n.flags[`PCRA_PF_TO] = 1'b1;
          n.flags[`PCRA_PF_PD] = 1'b1;
        end
        default: begin
          n.flags[`PCRA_PF_TO] = 1'b1;  // power-on, also unused code
          n.flags[`PCRA_PF_PD] = 1'b0;
        end
      endcase
    end
    // software writes to the register file
    if (reg_req.wr) begin
      case (reg_req.addr)
        `PCRA_OFS_PC: begin
          n.pc = reg_req.wdata[15:0];
        end
        `PCRA_OFS_ACC: begin
          n.acc = reg_req.wdata[7:0];
        end
        `PCRA_OFS_FLAGS: begin
          // cause bits are read only for software
          n.flags = (reg_req.wdata[7:0] & `PCRA_PF_SAVE_MASK)
                  | (q.flags & ~`PCRA_PF_SAVE_MASK);
        end
        `PCRA_OFS_MID: begin
          n.idx_mid = reg_req.wdata[7:0];
        end
        `PCRA_OFS_LOW: begin
          n.idx_low = reg_req.wdata[7:0];
        end
        default: begin
        end
      endcase
    end
    // command execution
    if (cmd_go) begin
      case (cmd_op)
        OP_TBLRD: begin
          n.state    = ST_ROM;
          n.rom.rd   = 1'b1;
          n.rom.addr = {q.idx_mid, q.idx_low};
        end
        OP_PUSH: begin
          n.sv_acc   = q.acc;
          n.sv_flags = q.flags & `PCRA_PF_SAVE_MASK;
        end
        OP_POP: begin
          n.acc   = q.sv_acc;
          n.flags = (q.sv_flags & `PCRA_PF_SAVE_MASK)
                  | (q.flags & ~`PCRA_PF_SAVE_MASK);
        end
        OP_IRQ: begin
          // a full stack drops the push but still vectors; nesting
          // deeper than the stack loses the newest return address
          if (q.sp < `PCRA_STACK_DEPTH) begin
            n.stack[sp_idx] = q.pc;
            n.sp            = q.sp + `PCRA_INC4;
          end
          n.pc = `PCRA_IRQ_VEC;
        end
        OP_RETURN: begin
          // an empty stack leaves the pc where it is
          if (q.sp != 4'h0) begin
            n.sp = sp_dec;
            n.pc = stack_top;
          end
        end
        OP_ADDPC: begin
          n.pc = pc_sum;
        end
        OP_SUBPC: begin
          n.pc = pc_sum;
        end
        OP_INCLOW: begin
          n.idx_low = q.idx_low + `PCRA_INC8;  // middle index untouched
        end
        OP_STEP: begin
          n.pc = q.pc + `PCRA_INC16;
        end
        default: begin
        end
      endcase
    end
    // rom word arrives while the request stands; it beats a bus write
    if (q.state == ST_ROM) begin
      n.acc   = rom_data[7:0];
      n.r     = rom_data[15:8];
      n.state = ST_IDLE;
    end
  end

  // state register; every reset brings the pc to the reset vector
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q            <= '0;
      q.pc         <= `PCRA_RESET_VEC;
      q.cause_pend <= 1'b1;
    end else if (cen) begin
      q <= n;
    end
  end

  // register read mux; unmapped addresses read zero
  always_comb begin
    reg_rdata = '0;
    case (reg_req.addr)
      `PCRA_OFS_STATUS: begin
        reg_rdata[`PCRA_ST_BUSY] = (q.state == ST_ROM);
        reg_rdata[`PCRA_ST_SP]   = q.sp;
      end
      `PCRA_OFS_PC: begin
        reg_rdata[15:0] = q.pc;
      end
      `PCRA_OFS_ACC: begin
        reg_rdata[7:0] = q.acc;
      end
      `PCRA_OFS_FLAGS: begin
        reg_rdata[7:0] = q.flags;
      end
      `PCRA_OFS_MID: begin
        reg_rdata[7:0] = q.idx_mid;
      end
      `PCRA_OFS_LOW: begin
        reg_rdata[7:0] = q.idx_low;
      end
      `PCRA_OFS_R: begin
        reg_rdata[7:0] = q.r;
      end
      `PCRA_OFS_SAVE: begin
        reg_rdata[15:0] = {q.sv_flags, q.sv_acc};
      end
      default: begin
      end
    endcase
  end

  assign rom_req = q.rom;
  assign pc_out  = q.pc;
  assign busy    = (q.state == ST_ROM);

  // helper views for the checks below
  logic [7:0] pc_hi;    // pc high byte
  logic [7:0] pc_lo;    // pc low byte
  logic [8:0] add_full; // pc low byte plus accumulator
  logic [7:0] rom_lo;   // rom word low byte
  logic [7:0] rom_hi;   // rom word high byte
  logic       flag_to;  // timeout flag
  logic       flag_pd;  // power-down flag
  logic       ex;       // command executes this edge
  assign pc_hi    = q.pc[`PCRA_PC_HI];
  assign pc_lo    = q.pc[`PCRA_PC_LO];
  assign add_full = {1'b0, pc_lo} + {1'b0, q.acc};
  assign rom_lo   = rom_data[7:0];
  assign rom_hi   = rom_data[15:8];
  assign flag_to  = q.flags[`PCRA_PF_TO];
  assign flag_pd  = q.flags[`PCRA_PF_PD];
  assign ex       = cmd_go && cen;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence tbl_start_s;
    ex && cmd_op == OP_TBLRD;
  endsequence
  sequence tbl_fetch_s;
    rom_req.rd && busy && rom_req.addr == {$past(q.idx_mid), $past(q.idx_low)};
  endsequence

  reset_vec_a: assert property (q.cause_pend |-> pc_out == `PCRA_RESET_VEC && !busy)
    else $error("pc not at reset vector after reset");
  cause_flag_a: assert property ($fell(q.cause_pend) |->
      flag_to == ($past(reset_src) != SRC_WDT) && flag_pd == ($past(reset_src) == SRC_EXT))
    else $error("reset cause flags wrong");
  irq_vector_a: assert property (ex && cmd_op == OP_IRQ && q.sp < `PCRA_STACK_DEPTH |=>
      pc_out == `PCRA_IRQ_VEC && q.stack[$past(sp_idx)] == $past(pc_out)
      && q.sp == $past(q.sp) + `PCRA_INC4)
    else $error("interrupt did not push pc and vector");
  pop_flags_a: assert property (ex && cmd_op == OP_POP |=> q.acc == $past(q.sv_acc)
      && flag_to == $past(flag_to) && flag_pd == $past(flag_pd))
    else $error("restore changed cause bits or missed accumulator");
  tbl_addr_a: assert property (tbl_start_s |=> tbl_fetch_s)
    else $error("table read address not formed from index pair");
  tbl_data_a: assert property (rom_req.rd && cen |=> q.acc == $past(rom_lo)
      && q.r == $past(rom_hi) && !busy)
    else $error("table word not split into accumulator and r");
  inc_low_a: assert property (ex && cmd_op == OP_INCLOW |=> q.idx_mid == $past(q.idx_mid)
      && q.idx_low == $past(q.idx_low) + `PCRA_INC8)
    else $error("low index step disturbed middle index");
  add_low_a: assert property (ex && cmd_op == OP_ADDPC |=> pc_lo == $past(add_full[7:0]))
    else $error("pc low byte not replaced by sum");
  add_carry_a: assert property (ex && cmd_op == OP_ADDPC |=>
      pc_hi == ($past(add_full[`PCRA_CARRY]) ? $past(pc_hi) + `PCRA_INC8 : $past(pc_hi)))
    else $error("pc high byte did not follow carry");
  sub_hold_a: assert property (ex && cmd_op == OP_SUBPC |=> pc_hi == $past(pc_hi)
      && pc_lo == $past(pc_lo) - $past(q.acc))
    else $error("subtract moved pc high byte");
  ret_pop_a: assert property (ex && cmd_op == OP_RETURN && q.sp != 4'h0 |=>
      pc_out == $past(stack_top) && q.sp == $past(sp_dec))
    else $error("return did not restore saved pc");

endmodule

// ### inc/pcra_consts.svh
`ifndef PCRA_CONSTS_SVH
`define PCRA_CONSTS_SVH

// program counter vectors
`define PCRA_RESET_VEC    16'h0000
`define PCRA_IRQ_VEC      16'h0008

// byte fields of the program counter
`define PCRA_PC_LO        7:0
`define PCRA_PC_HI        15:8
`define PCRA_CARRY        8

// hardware stack: depth in entries, index field of the pointer
`define PCRA_STACK_DEPTH  4'h8
`define PCRA_SP_IDX       2:0

// program flag register: reset-cause bits and the save/restore mask
`define PCRA_PF_TO        7
`define PCRA_PF_PD        6
`define PCRA_PF_SAVE_MASK 8'h3F

// increments
`define PCRA_INC4         4'h1
`define PCRA_INC8         8'h01
`define PCRA_INC16        16'h0001

// register byte addresses on the bus
`define PCRA_OFS_CMD      32'h0000_0000
`define PCRA_OFS_STATUS   32'h0000_0004
`define PCRA_OFS_PC       32'h0000_0008
`define PCRA_OFS_ACC      32'h0000_000C
`define PCRA_OFS_FLAGS    32'h0000_0010
`define PCRA_OFS_MID      32'h0000_0014
`define PCRA_OFS_LOW      32'h0000_0018
`define PCRA_OFS_R        32'h0000_001C
`define PCRA_OFS_SAVE     32'h0000_0020

// status register fields
`define PCRA_ST_BUSY      0
`define PCRA_ST_SP        7:4

// command field and bus encodings
`define PCRA_CMD_OP       3:0
`define PCRA_HSIZE_WORD   3'h2
`define PCRA_HTRANS_ACT   1

`endif

// ### inc/pcra_pkg.sv
`include "pcra_consts.svh"
package pcra_pkg;

  // commands written to the command register
  typedef enum logic [3:0] {
    OP_NOP    = 4'b0000,
    OP_TBLRD  = 4'b0001,
    OP_PUSH   = 4'b0010,
    OP_POP    = 4'b0011,
    OP_IRQ    = 4'b0100,
    OP_RETURN = 4'b0101,
    OP_ADDPC  = 4'b0110,
    OP_SUBPC  = 4'b0111,
    OP_INCLOW = 4'b1000,
    OP_STEP   = 4'b1001
  } pcra_op_t;

  // cause of the last reset, presented by the reset controller
  typedef enum logic [1:0] {
    SRC_POR = 2'b00,
    SRC_WDT = 2'b01,
    SRC_EXT = 2'b10
  } pcra_rst_src_t;

  // core sequencer
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_ROM  = 1'b1
  } pcra_fsm_t;

  // bus slave phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WR   = 2'b01,
    PH_RD1  = 2'b10,
    PH_RD2  = 2'b11
  } pcra_phase_t;

  // program rom request
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } pcra_rom_req_t;

  // register access from the bus slave
  typedef struct packed {
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pcra_reg_req_t;

  // bus slave state
  typedef struct packed {
    pcra_phase_t ph;
    logic [31:0] addr;
    logic [31:0] rdata;
  } pcra_ahb_st_t;

  // core state
  typedef struct packed {
    pcra_fsm_t                                 state;
    logic                                      cause_pend;
    logic [15:0]                               pc;
    logic [7:0]                                acc;
    logic [7:0]                                flags;
    logic [7:0]                                idx_mid;
    logic [7:0]                                idx_low;
    logic [7:0]                                r;
    logic [7:0]                                sv_acc;
    logic [7:0]                                sv_flags;
    logic [3:0]                                sp;
    logic [`PCRA_STACK_DEPTH-1:0][15:0]        stack;
    pcra_rom_req_t                             rom;
  } pcra_core_st_t;

endpackage

// ### hw/pcra_pc_add.sv
`timescale 1ns/10ps
`include "pcra_consts.svh"
module pcra_pc_add
  import pcra_pkg::*;
(
  input  wire logic [15:0] pc_in,   // current program counter
  input  wire logic [7:0]  addend,  // accumulator value
  input  wire logic        sub,     // subtract instead of add
  output logic      [15:0] pc_out   // computed program counter
);

  logic [8:0] low_res;  // low byte result with carry

  // low byte arithmetic; only a carry moves the high byte
  always_comb begin
    if (sub) begin
      // a borrow is dropped: the high byte cannot count down
      low_res = {1'b0, pc_in[`PCRA_PC_LO] - addend};
    end else begin
      low_res = {1'b0, pc_in[`PCRA_PC_LO]} + {1'b0, addend};
    end
    pc_out[`PCRA_PC_LO] = low_res[7:0];
    if (low_res[`PCRA_CARRY]) begin
      pc_out[`PCRA_PC_HI] = pc_in[`PCRA_PC_HI] + `PCRA_INC8;
    end else begin
      pc_out[`PCRA_PC_HI] = pc_in[`PCRA_PC_HI];
    end
  end

endmodule

// ### hw/pcra_ahb_slave.sv
`timescale 1ns/10ps
`include "pcra_consts.svh"
module pcra_ahb_slave
  import pcra_pkg::*;
(
  input  wire logic          ref_clk,    // instruction clock
  input  wire logic          nrst,       // async reset, active low
  input  wire logic          cen,        // clock enable
  input  wire logic          hsel,       // slave select
  input  wire logic [31:0]   haddr,      // byte address
  input  wire logic [1:0]    htrans,     // transfer type
  input  wire logic          hwrite,     // write when high
  input  wire logic [2:0]    hsize,      // transfer size
  input  wire logic [31:0]   hwdata,     // write data
  input  wire logic          hready,     // bus ready
  output logic               hreadyout,  // slave ready
  output logic      [31:0]   hrdata,     // read data
  output logic               hresp,      // always okay
  output pcra_reg_req_t      reg_req,    // register access to the core
  input  wire logic [31:0]   reg_rdata   // register read value
);

  pcra_ahb_st_t q;  // registered state
  pcra_ahb_st_t n;  // next state

  // phase sequencing; reads take one wait state so that a write in
  // the previous data phase is always visible to the next read
  always_comb begin
    n = q;
    case (q.ph)
      PH_RD1: begin
        n.rdata = reg_rdata;  // sample the register mux
        n.ph    = PH_RD2;
      end
      default: begin
        n.ph = PH_IDLE;
      end
    endcase
    if (q.ph != PH_RD1 && hready && hsel && htrans[`PCRA_HTRANS_ACT]) begin
      n.addr = haddr;
      if (!hwrite) begin
        n.ph = PH_RD1;
      end else if (hsize == `PCRA_HSIZE_WORD) begin
        n.ph = PH_WR;
      end else begin
        n.ph = PH_IDLE;  // narrow writes are dropped
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (cen) begin
      q <= n;
    end
  end

  assign hreadyout = (q.ph != PH_RD1);
  assign hrdata    = q.rdata;
  assign hresp     = 1'b0;
  assign reg_req   = {(q.ph == PH_WR), q.addr, hwdata};

endmodule

// ### verification/pcra_rom_model.sv
`timescale 1ns/10ps
module pcra_rom_model
  import pcra_pkg::*;
(
  input  wire logic          ref_clk,  // instruction clock
  input  wire pcra_rom_req_t rom_req,  // read request from the core
  output logic        [15:0] rom_data  // program word
);
  localparam logic [15:0] NOP_WORD = 16'h0000;  // arbitrary no-op encoding

  logic [15:0] last_q = 16'h0000;  // word shown in the previous cycle

  // content is a scramble of the address, so an address slip shows in the data, except between 0x0008 and 0x3C5A, which both read 0x0000
  function automatic logic [15:0] word_at(input logic [15:0] a);
    if (a == 16'h0008) begin
      return NOP_WORD;  // vector code opens with a no-op
    end
    return {a[7:0] ^ 8'h5A, a[15:8] ^ 8'h3C};
  endfunction

  // outside a read the port shows the inverse of the previous cycle's word, so idle cycles alternate and every second one shows stale data
  assign rom_data = (rom_req.rd === 1'b1) ? word_at(rom_req.addr) : ~last_q;

  // remember what was shown for the idle pattern
  always @(posedge ref_clk) begin
    last_q <= rom_data;
  end
endmodule

// ### verification/tb.sv
`timescale 1ns/10ps
`include "pcra_consts.svh"
module tb;
  import pcra_pkg::*;

  logic          ref_clk = 1'b0;  // 20 MHz clock
  logic          nrst;            // reset, active low
  logic          cen;             // clock enable
  pcra_rst_src_t reset_src;       // reset cause
  logic          hsel;            // bus select
  logic [31:0]   haddr;           // bus address
  logic [1:0]    htrans;          // transfer type
  logic          hwrite;          // write flag
  logic [2:0]    hsize;           // transfer size
  logic [31:0]   hwdata;          // write data
  wire           hready;          // bus ready
  logic          hreadyout;       // slave ready
  logic [31:0]   hrdata;          // read data
  logic          hresp;           // response
  pcra_rom_req_t rom_req;         // rom request
  logic [15:0]   rom_data;        // rom word
  logic [15:0]   pc_out;          // program counter
  logic          busy;            // table read in flight
  logic [15:0]   seen_addr;       // last rom address requested
  logic          seen_busy;       // busy level seen with that request
  logic [15:0]   seed;            // random state
  int            errors;          // mismatches
  int            total_checks;    // comparisons
  int            cycles;          // run length

  assign hready = hreadyout;  // single slave drives the bus ready

  pcra_core u_pcra_core (.ref_clk(ref_clk), .nrst(nrst), .cen(cen), .reset_src(reset_src),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .rom_req(rom_req), .rom_data(rom_data), .pc_out(pc_out), .busy(busy));

  pcra_rom_model u_pcra_rom_model (.ref_clk(ref_clk), .rom_req(rom_req), .rom_data(rom_data));

  // clock
  always begin
    #25 ref_clk = ~ref_clk;
  end

  // catch the address of every rom read
  always @(posedge ref_clk) begin
    if (rom_req.rd === 1'b1) begin
      seen_addr <= rom_req.addr;
      seen_busy <= busy;
    end
  end

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] exp_word(input logic [15:0] a);
    return (a == 16'h0008) ? 16'h0000 : {a[7:0] ^ 8'h5A, a[15:8] ^ 8'h3C};
  endfunction

  // timeout bit over power-down bit for each cause
  function automatic logic [1:0] exp_cause(input pcra_rst_src_t s);
    return (s == SRC_WDT) ? 2'b00 : (s == SRC_EXT) ? 2'b11 : 2'b10;
  endfunction

  // only a carry reaches the high byte; a borrow is dropped
  function automatic logic [15:0] exp_jump(input logic [15:0] p, input logic [7:0] a,
                                           input logic sub);
    logic [8:0] s;
    s = sub ? {1'b0, p[7:0]} - {1'b0, a} : {1'b0, p[7:0]} + {1'b0, a};
    return {sub ? p[15:8] : p[15:8] + {7'h00, s[8]}, s[7:0]};
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_addr(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t rom address %h expected %h", $time, got, exp);
    end
  endtask

  // hready is settled between edges, so the low phase shows what the edge samples
  // no wait limit here: only the cycle ceiling ends a hung transfer
  task automatic wait_rdy(output logic [31:0] q);
    logic ok;
    ok = 1'b0;
    while (!ok) begin
      @(negedge ref_clk);
      ok = (hreadyout === 1'b1);
      q = hrdata;
      @(posedge ref_clk);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic [31:0] dummy;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= `PCRA_HSIZE_WORD;
    wait_rdy(dummy);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy(q);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask

  task automatic cmd(input pcra_op_t op);
    wr(`PCRA_OFS_CMD, {28'h000_0000, op});
  endtask

  task automatic do_reset(input pcra_rst_src_t s);
    reset_src <= s;
    nrst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
  endtask

  // main sequence
  initial begin
    logic [31:0] q;
    logic [15:0] p;
    logic [7:0]  a;
    logic [7:0]  f;
    logic [7:0]  lo;
    logic [15:0] w;
    {nrst, cen, hsel, hwrite, htrans, hsize} = '0;
    {haddr, hwdata} = '0;
    reset_src = SRC_POR;
    seed = 16'h05CF;
    cen = 1'b1;
    do_reset(SRC_POR);
    for (int i = 0; i < 3; i++) begin
      wr(`PCRA_OFS_ACC, 32'h0000_00A7);
      wr(`PCRA_OFS_PC, 32'h0000_1234);
      do_reset(pcra_rst_src_t'(i));
      rd(`PCRA_OFS_PC, q);
      chk_word(q, 32'h0000_0000);
      rd(`PCRA_OFS_ACC, q);
      chk_word(q, 32'h0000_0000);
      rd(`PCRA_OFS_FLAGS, q);
      chk_word(q, {24'h00_0000, exp_cause(pcra_rst_src_t'(i)), 6'h00});
    end
    // a held clock enable freezes the core through a whole write transfer
    cen <= 1'b0;
    wr(`PCRA_OFS_PC, 32'h0000_5555);
    cen <= 1'b1;
    rd(`PCRA_OFS_PC, q);
    chk_word(q, 32'h0000_0000);
    cmd(OP_STEP);
    rd(`PCRA_OFS_PC, q);
    chk_word(q, 32'h0000_0001);
    // save and restore keep the cause bits out of the buffer
    seed = lfsr(seed);
    a = seed[7:0];
    f = seed[15:8];
    wr(`PCRA_OFS_ACC, {24'h00_0000, a});
    wr(`PCRA_OFS_FLAGS, {24'h00_0000, f});
    cmd(OP_PUSH);
    rd(`PCRA_OFS_SAVE, q);
    chk_word(q, {16'h0000, 2'b00, f[5:0], a});
    wr(`PCRA_OFS_ACC, {24'h00_0000, ~a});
    wr(`PCRA_OFS_FLAGS, {24'h00_0000, ~f});
    cmd(OP_POP);
    rd(`PCRA_OFS_ACC, q);
    chk_word(q, {24'h00_0000, a});
    rd(`PCRA_OFS_FLAGS, q);
    chk_word(q, {24'h00_0000, 2'b11, f[5:0]});
    // table reads, low index at the wrap point and the vector word first
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      p = (k == 0) ? {seed[15:8], 8'hFF} : (k == 1) ? 16'h0008 : seed;
      wr(`PCRA_OFS_MID, {24'h00_0000, p[15:8]});
      wr(`PCRA_OFS_LOW, {24'h00_0000, p[7:0]});
      cmd(OP_TBLRD);
      w = exp_word(p);
      rd(`PCRA_OFS_ACC, q);
      chk_word(q, {24'h00_0000, w[7:0]});
      chk_addr(seen_addr, p);
      chk_word({31'h0000_0000, seen_busy}, 32'h0000_0001);
      rd(`PCRA_OFS_R, q);
      chk_word(q, {24'h00_0000, w[15:8]});
      cmd(OP_INCLOW);
      lo = p[7:0] + 8'h01;
      rd(`PCRA_OFS_LOW, q);
      chk_word(q, {24'h00_0000, lo});
      rd(`PCRA_OFS_MID, q);
      chk_word(q, {24'h00_0000, p[15:8]});
    end
    // interrupt entry and return
    seed = lfsr(seed);
    wr(`PCRA_OFS_PC, {16'h0000, seed});
    cmd(OP_IRQ);
    rd(`PCRA_OFS_PC, q);
    chk_word(q, 32'h0000_0008);
    rd(`PCRA_OFS_STATUS, q);
    chk_word(q, 32'h0000_0010);
    cmd(OP_RETURN);
    rd(`PCRA_OFS_PC, q);
    chk_word(q, {16'h0000, seed});
    // computed jumps, carry and borrow corners first
    for (int k = 0; k < 10; k++) begin
      seed = lfsr(seed);
      p = (k == 0) ? 16'h12FD : (k == 1) ? 16'h3402 : seed;
      a = (k < 2) ? 8'h05 : seed[11:4];
      wr(`PCRA_OFS_PC, {16'h0000, p});
      wr(`PCRA_OFS_ACC, {24'h00_0000, a});
      cmd(k[0] ? OP_SUBPC : OP_ADDPC);
      rd(`PCRA_OFS_PC, q);
      chk_word(q, {16'h0000, exp_jump(p, a, k[0])});
      chk_word({16'h0000, pc_out}, {16'h0000, exp_jump(p, a, k[0])});
    end
    // unmapped place reads zero after a write
    wr(32'h0000_0040, 32'hFFFF_FFFF);
    rd(32'h0000_0040, q);
    chk_word(q, 32'h0000_0000);
    chk_word({31'h0000_0000, hresp}, 32'h0000_0000);
    print_verdict();
  end
endmodule
